// >>> common/qsr_defs.vh
`ifndef QSR_DEFS_VH
`define QSR_DEFS_VH

// Register selectors on the command port
`define QSR_SEL_FLT_EVT 4'h0
`define QSR_SEL_FLT_COND 4'h1
`define QSR_SEL_FLT_ENA 4'h2
`define QSR_SEL_OPR_EVT 4'h3
`define QSR_SEL_OPR_COND 4'h4
`define QSR_SEL_OPR_ENA 4'h5
`define QSR_SEL_STB 4'h6
`define QSR_SEL_BUS_ADDR 4'h7

// Fault field positions
`define QSR_FLT_OVERVOLTAGE 0
`define QSR_FLT_OVERCURRENT 1
`define QSR_FLT_OUTPUT_LEAD 2
`define QSR_FLT_OVERTEMP 3
`define QSR_FLT_SOURCE_POWER_LOSS 4
`define QSR_FLT_COOLING 5
`define QSR_FLT_MASTER_SLAVE 6
`define QSR_FLT_USED_MASK 16'h007f

// Operation field positions
`define QSR_OPR_CALIBRATION 0
`define QSR_OPR_WAIT_FOR_TRIGGER 5
`define QSR_OPR_CONSTANT_VOLTAGE 8
`define QSR_OPR_CONSTANT_CURRENT 10
`define QSR_OPR_PROGRAM_RUNNING 14
`define QSR_OPR_USED_MASK 16'h4521

// Status byte summary bits
`define QSR_STB_FAULT_SUM 3
`define QSR_STB_OPER_SUM 7

// Reset values and address limits
`define QSR_ENA_RST 16'h0000
`define QSR_BUS_ADDR_RST 5'h01
`define QSR_BUS_ADDR_MIN 5'h01
`define QSR_BUS_ADDR_MAX 5'h1e

// Settle time of the pin synchroniser before the retained-loss sample
`define QSR_SEED_WAIT 3'h4

`endif

// >>> hw/qsr_event_latch.v
`timescale 1ns/1ps
`include "qsr_defs.vh"

module qsr_event_latch (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [15:0] used_i,
    input wire [15:0] cond_i,
    input wire [15:0] preset_i,
    input wire rd_clr_i,
    output reg [15:0] evt_o
);
    wire [15:0] evt_nxt;

    // Set wins over the clear-on-read
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_bit
            assign evt_nxt[g] = used_i[g] & (cond_i[g] | preset_i[g] |
                                (evt_o[g] & ~rd_clr_i));
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            evt_o <= 16'h0000;
        end else if (ce_i) begin
            evt_o <= evt_nxt;
        end
    end
endmodule

// >>> hw/qsr_status_top.v
`timescale 1ns/1ps
`include "qsr_defs.vh"


module qsr_status_top (
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire CLK_EN_I,
    input wire OVERVOLTAGE_FAULT_I,
    input wire OVERCURRENT_FAULT_I,
    input wire OUTPUT_LEAD_FAULT_I,
    input wire OVERTEMP_FAULT_I,
    input wire SOURCE_POWER_LOSS_I,
    input wire COOLING_FAILURE_I,
    input wire MASTER_SLAVE_FAULT_I,
    input wire POWER_LOSS_RETAINED_I,
    input wire CALIBRATION_I,
    input wire CONSTANT_VOLTAGE_STATE_I,
    input wire CONSTANT_CURRENT_STATE_I,
    input wire PROGRAM_RUNNING_I,
    input wire TRIGGER_ARMED_I,
    input wire CONT_TRIGGER_I,
    input wire REQ_I,
    input wire WR_I,
    input wire [3:0] SEL_I,
    input wire [15:0] WDATA_I,
    input wire PRESET_I,
    output reg [15:0] RDATA_O,
    output reg ACK_O,
    output reg ERR_O,
    output reg [7:0] STATUS_BYTE_O,
    output reg [4:0] BUS_ADDR_O,
    output reg OUTPUT_ENABLE_O,
    input wire OUTPUT_ON_REQ_I,
    input wire OUTPUT_OFF_REQ_I
);
    // =====================================================
    // Pin synchronisers (three stages)
    // =====================================================
    localparam NPIN = 14;
    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] s1_r;
    reg [NPIN-1:0] s2_r;
    reg [NPIN-1:0] s3_r;
    reg [NPIN-1:0] pin_r;

    assign pin_raw = {TRIGGER_ARMED_I, CONT_TRIGGER_I, PROGRAM_RUNNING_I,
                      CONSTANT_CURRENT_STATE_I, CONSTANT_VOLTAGE_STATE_I,
                      CALIBRATION_I, POWER_LOSS_RETAINED_I,
                      MASTER_SLAVE_FAULT_I, COOLING_FAILURE_I,
                      SOURCE_POWER_LOSS_I, OVERTEMP_FAULT_I,
                      OUTPUT_LEAD_FAULT_I, OVERCURRENT_FAULT_I,
                      OVERVOLTAGE_FAULT_I};

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_sync
            always @(posedge SYS_CLK_I) begin
                if (SYS_RST_I) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    pin_r[g] <= 1'b0;
                end else if (CLK_EN_I) begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        pin_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    // =====================================================
    // Live condition vectors
    // =====================================================
    wire [15:0] flt_cond;
    wire [15:0] opr_cond;
    wire trig_wait_live;

    assign flt_cond = {9'h000, pin_r[6:0]};
    assign trig_wait_live = pin_r[13] | pin_r[12];
    assign opr_cond = {1'b0, pin_r[11], 3'h0, pin_r[10], 1'b0, pin_r[9],
                       2'h0, trig_wait_live, 4'h0, pin_r[8]};

    // =====================================================
    // Command port decode
    // =====================================================
    wire take;
    wire rd_flt_evt;
    wire rd_opr_evt;
    reg [15:0] flt_ena_r;
    reg [15:0] opr_ena_r;
    reg [4:0] bus_addr_r;
    reg loss_seed_r;
    reg [2:0] seed_cnt_r;
    wire [15:0] flt_evt;
    wire [15:0] opr_evt;
    wire [15:0] flt_preset;
    wire fault_sum;
    wire oper_sum;

    assign take = CLK_EN_I & REQ_I;
    assign rd_flt_evt = take & ~WR_I & (SEL_I == `QSR_SEL_FLT_EVT);
    assign rd_opr_evt = take & ~WR_I & (SEL_I == `QSR_SEL_OPR_EVT);

    // Retained power-loss seeded once after reset release
    assign flt_preset = {11'h000, loss_seed_r, 4'h0};

    qsr_event_latch u_flt_evt (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .ce_i(CLK_EN_I),
        .used_i(`QSR_FLT_USED_MASK),
        .cond_i(flt_cond),
        .preset_i(flt_preset),
        .rd_clr_i(rd_flt_evt),
        .evt_o(flt_evt)
    );

    qsr_event_latch u_opr_evt (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .ce_i(CLK_EN_I),
        .used_i(`QSR_OPR_USED_MASK),
        .cond_i(opr_cond),
        .preset_i(16'h0000),
        .rd_clr_i(rd_opr_evt),
        .evt_o(opr_evt)
    );

    assign fault_sum = |(flt_evt & flt_ena_r);
    assign oper_sum = |(opr_evt & opr_ena_r);

    // =====================================================
    // Registers and power-loss seed
    // =====================================================
    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            flt_ena_r <= `QSR_ENA_RST;
            opr_ena_r <= `QSR_ENA_RST;
            bus_addr_r <= `QSR_BUS_ADDR_RST;
            loss_seed_r <= 1'b0;
            seed_cnt_r <= 3'h0;
        end else if (CLK_EN_I) begin
            loss_seed_r <= 1'b0;
            // Sample only once the synchroniser holds the pin level
            if (seed_cnt_r < `QSR_SEED_WAIT) begin
                seed_cnt_r <= seed_cnt_r + 3'h1;
            end else if (seed_cnt_r == `QSR_SEED_WAIT) begin
                seed_cnt_r <= seed_cnt_r + 3'h1;
                loss_seed_r <= pin_r[7];
            end
            if (PRESET_I) begin
                flt_ena_r <= 16'h0000;
                opr_ena_r <= 16'h0000;
            end else if (take && WR_I) begin
                if (SEL_I == `QSR_SEL_FLT_ENA) begin
                    flt_ena_r <= WDATA_I & `QSR_FLT_USED_MASK;
                end else if (SEL_I == `QSR_SEL_OPR_ENA) begin
                    opr_ena_r <= WDATA_I & `QSR_OPR_USED_MASK;
                end else if (SEL_I == `QSR_SEL_BUS_ADDR) begin
                    if (WDATA_I >= {11'h000, `QSR_BUS_ADDR_MIN} &&
                        WDATA_I <= {11'h000, `QSR_BUS_ADDR_MAX}) begin
                        bus_addr_r <= WDATA_I[4:0];
                    end
                end
            end
        end
    end

    // =====================================================
    // Read answer, status byte, output control
    // =====================================================
    reg [15:0] rd_mux;
    reg bad_sel;
    reg bad_wr;

    always @* begin
        rd_mux = 16'h0000;
        bad_sel = 1'b0;
        if (SEL_I == `QSR_SEL_FLT_EVT) begin
            rd_mux = flt_evt;
        end else if (SEL_I == `QSR_SEL_FLT_COND) begin
            rd_mux = flt_cond;
        end else if (SEL_I == `QSR_SEL_FLT_ENA) begin
            rd_mux = flt_ena_r;
        end else if (SEL_I == `QSR_SEL_OPR_EVT) begin
            rd_mux = opr_evt;
        end else if (SEL_I == `QSR_SEL_OPR_COND) begin
            rd_mux = opr_cond;
        end else if (SEL_I == `QSR_SEL_OPR_ENA) begin
            rd_mux = opr_ena_r;
        end else if (SEL_I == `QSR_SEL_STB) begin
            rd_mux = {8'h00, STATUS_BYTE_O};
        end else if (SEL_I == `QSR_SEL_BUS_ADDR) begin
            rd_mux = {11'h000, bus_addr_r};
        end else begin
            bad_sel = 1'b1;
        end
        // Writes to read-only or out-of-range values are refused
        bad_wr = (SEL_I != `QSR_SEL_FLT_ENA) && (SEL_I != `QSR_SEL_OPR_ENA) &&
                 (SEL_I != `QSR_SEL_BUS_ADDR);
        if (SEL_I == `QSR_SEL_BUS_ADDR &&
            (WDATA_I < {11'h000, `QSR_BUS_ADDR_MIN} ||
             WDATA_I > {11'h000, `QSR_BUS_ADDR_MAX})) begin
            bad_wr = 1'b1;
        end
    end

    always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            RDATA_O <= 16'h0000;
            ACK_O <= 1'b0;
            ERR_O <= 1'b0;
            STATUS_BYTE_O <= 8'h00;
            BUS_ADDR_O <= `QSR_BUS_ADDR_RST;
            OUTPUT_ENABLE_O <= 1'b0;
        end else if (CLK_EN_I) begin
            ACK_O <= REQ_I;
            ERR_O <= REQ_I & (bad_sel | (WR_I & bad_wr));
            if (REQ_I && !WR_I) begin
                RDATA_O <= rd_mux;
            end
            STATUS_BYTE_O <= 8'h00;
            STATUS_BYTE_O[`QSR_STB_FAULT_SUM] <= fault_sum;
            STATUS_BYTE_O[`QSR_STB_OPER_SUM] <= oper_sum;
            BUS_ADDR_O <= bus_addr_r;
            if (flt_cond[`QSR_FLT_OVERVOLTAGE]) begin
                OUTPUT_ENABLE_O <= 1'b0;
            end else if (OUTPUT_OFF_REQ_I) begin
                OUTPUT_ENABLE_O <= 1'b0;
            end else if (OUTPUT_ON_REQ_I) begin
                OUTPUT_ENABLE_O <= 1'b1;
            end
        end
    end
endmodule

// >>> verif/qsr_host_model.sv
`timescale 1ns/1ps
// ====================
// Host side of the command port
module qsr_host (
    input logic clk_i,
    input logic ack_i,
    input logic err_i,
    input logic [15:0] rdata_i,
    output logic req_o,
    output logic wr_o,
    output logic [3:0] sel_o,
    output logic [15:0] wdata_o,
    output logic preset_o
);
    initial {req_o, wr_o, sel_o, wdata_o, preset_o} = '0;
    // One access, bounded wait for the answer
    task automatic acc(input logic w, input logic [3:0] s, input logic [15:0] d,
            output logic [15:0] q, output logic e);
        int n = 0;
        @(posedge clk_i) #1 req_o = 1'b1;
        wr_o = w;
        sel_o = s;
        wdata_o = d;
        @(posedge clk_i) #1 req_o = 1'b0;
        wdata_o = ~d;
        while (ack_i !== 1'b1 && n < 8) begin
            @(posedge clk_i) #1 n++;
        end
        q = rdata_i;
        e = err_i;
    endtask
    task automatic pre();
        @(posedge clk_i) #1 preset_o = 1'b1;
        @(posedge clk_i) #1 preset_o = 1'b0;
    endtask
endmodule

// >>> verif/qsr_status_assertions.sv
`timescale 1ns/1ps
// ====================
// Status bank checker
module qsr_chk (
    input logic SYS_CLK_I,
    input logic SYS_RST_I,
    input logic CLK_EN_I,
    input logic REQ_I,
    input logic WR_I,
    input logic [3:0] SEL_I,
    input logic [15:0] WDATA_I,
    input logic PRESET_I,
    input logic OVERVOLTAGE_FAULT_I,
    input logic [15:0] RDATA_O,
    input logic ACK_O,
    input logic ERR_O,
    input logic [7:0] STATUS_BYTE_O,
    input logic [4:0] BUS_ADDR_O,
    input logic OUTPUT_ENABLE_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire rd_req = CLK_EN_I && REQ_I && !WR_I;
    wire wr_req = CLK_EN_I && REQ_I && WR_I;
    a_ack_timing: assert property ($past(CLK_EN_I) |-> ACK_O == $past(REQ_I))
        else $error("ack not one cycle after request");
    a_evt_write_err: assert property (wr_req && SEL_I == 4'h0 |=> ERR_O && ACK_O)
        else $error("event write not refused");
    a_addr_range: assert property (BUS_ADDR_O >= 5'h01 && BUS_ADDR_O <= 5'h1e)
        else $error("bus address out of range");
    a_addr_write: assert property (wr_req && SEL_I == 4'h7 && WDATA_I >= 16'h0001
        && WDATA_I <= 16'h001e |=> !ERR_O ##1 {11'h000, BUS_ADDR_O} == $past(WDATA_I, 2))
        else $error("legal address not taken");
    a_overvoltage_off: assert property ((OVERVOLTAGE_FAULT_I && CLK_EN_I) [*6]
        |=> !OUTPUT_ENABLE_O)
        else $error("output on during overvoltage");
    a_cond_live: assert property ((OVERVOLTAGE_FAULT_I && CLK_EN_I) [*6]
        ##0 (rd_req && SEL_I == 4'h1) |=> RDATA_O[0])
        else $error("condition bit not live");
    a_evt_unused: assert property (rd_req && SEL_I == 4'h0 |=> RDATA_O[15:7] == 9'h000)
        else $error("unused event bits set");
    a_stb_unused: assert property ((STATUS_BYTE_O & 8'h77) == 8'h00)
        else $error("unused status bits set");
    a_preset_clear: assert property (CLK_EN_I && PRESET_I |-> ##2 STATUS_BYTE_O == 8'h00)
        else $error("status not cleared by preset");
    a_mask_readback: assert property (wr_req && SEL_I == 4'h2 && !PRESET_I ##1
        !REQ_I && !PRESET_I ##1 rd_req && SEL_I == 4'h2
        |=> RDATA_O == ($past(WDATA_I, 3) & 16'h007f))
        else $error("mask readback wrong");
    c_err: cover property (ERR_O);
    c_fault_sum: cover property (STATUS_BYTE_O[3]);
    c_oper_sum: cover property (STATUS_BYTE_O[7]);
endmodule

bind qsr_status_top qsr_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
    .CLK_EN_I(CLK_EN_I), .REQ_I(REQ_I), .WR_I(WR_I), .SEL_I(SEL_I),
    .WDATA_I(WDATA_I), .PRESET_I(PRESET_I),
    .OVERVOLTAGE_FAULT_I(OVERVOLTAGE_FAULT_I), .RDATA_O(RDATA_O), .ACK_O(ACK_O),
    .ERR_O(ERR_O), .STATUS_BYTE_O(STATUS_BYTE_O), .BUS_ADDR_O(BUS_ADDR_O),
    .OUTPUT_ENABLE_O(OUTPUT_ENABLE_O));

// >>> verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] flt = 7'h00;
    logic [3:0] opr = 4'h0;
    logic cont = 1'b0;
    logic loss_kept = 1'b1;
    logic ce = 1'b1;
    logic arm = 1'b0;
    logic on_req = 1'b0;
    logic req, wr, preset, ack, err, oen;
    logic [3:0] sel;
    logic [15:0] wdata, rdata;
    logic [7:0] stb;
    logic [4:0] addr;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    qsr_status_top dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(ce),
        .OVERVOLTAGE_FAULT_I(flt[0]), .OVERCURRENT_FAULT_I(flt[1]),
        .OUTPUT_LEAD_FAULT_I(flt[2]), .OVERTEMP_FAULT_I(flt[3]),
        .SOURCE_POWER_LOSS_I(flt[4]), .COOLING_FAILURE_I(flt[5]),
        .MASTER_SLAVE_FAULT_I(flt[6]), .POWER_LOSS_RETAINED_I(loss_kept),
        .CALIBRATION_I(opr[0]), .CONSTANT_VOLTAGE_STATE_I(opr[1]),
        .CONSTANT_CURRENT_STATE_I(opr[2]), .PROGRAM_RUNNING_I(opr[3]),
        .TRIGGER_ARMED_I(arm), .CONT_TRIGGER_I(cont), .REQ_I(req), .WR_I(wr),
        .SEL_I(sel), .WDATA_I(wdata), .PRESET_I(preset), .RDATA_O(rdata), .ACK_O(ack),
        .ERR_O(err), .STATUS_BYTE_O(stb), .BUS_ADDR_O(addr), .OUTPUT_ENABLE_O(oen),
        .OUTPUT_ON_REQ_I(on_req), .OUTPUT_OFF_REQ_I(1'b0));
    qsr_host host (.clk_i(clk), .ack_i(ack), .err_i(err), .rdata_i(rdata), .req_o(req),
        .wr_o(wr), .sel_o(sel), .wdata_o(wdata), .preset_o(preset));
    // ====================
    // Access and closing tasks
    task automatic xs(input logic w, input logic [3:0] s, input logic [15:0] d,
            input logic [15:0] eq, input logic ee);
        logic [15:0] q;
        logic e;
        host.acc(w, s, d, q, e);
        if (!w) `CHK(q, eq)
        `CHK(e, ee)
        `CHK(ack, 1'b1)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            conclude();
        end
    end
    // ====================
    // Test sequence
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        on_req = 1'b1;
        idle(10);
        on_req = 1'b0;
        loss_kept = 1'b0;
        xs(0, 4'h0, 0, 16'h0010, 0);
        xs(0, 4'h0, 0, 16'h0000, 0);
        `CHK(oen, 1'b1)
        for (int i = 0; i < 7; i++) begin
            flt = 7'h01 << i;
            idle(6);
            if (i == 0) `CHK(oen, 1'b0)
            xs(0, 4'h1, 0, 16'h0001 << i, 0);
            flt = 7'h00;
            idle(6);
            xs(0, 4'h1, 0, 16'h0000, 0);
        end
        xs(0, 4'h0, 0, 16'h007f, 0);
        xs(0, 4'h0, 0, 16'h0000, 0);
        xs(1, 4'h2, 16'hffff, 0, 0);
        xs(0, 4'h2, 0, 16'h007f, 0);
        xs(1, 4'h2, 16'h0003, 0, 0);
        flt = 7'h04;
        idle(6);
        flt = 7'h00;
        idle(3);
        `CHK(stb, 8'h00)
        flt = 7'h02;
        idle(6);
        flt = 7'h00;
        idle(3);
        `CHK(stb, 8'h08)
        xs(0, 4'h0, 0, 16'h0006, 0);
        idle(2);
        `CHK(stb, 8'h00)
        xs(1, 4'h0, 16'h0001, 0, 1);
        xs(0, 4'h0, 0, 16'h0000, 0);
        opr = 4'hf;
        cont = 1'b1;
        idle(6);
        xs(0, 4'h4, 0, 16'h4521, 0);
        opr = 4'h0;
        idle(6);
        xs(0, 4'h3, 0, 16'h4521, 0);
        xs(0, 4'h3, 0, 16'h0020, 0);
        xs(1, 4'h5, 16'h0520, 0, 0);
        xs(0, 4'h5, 0, 16'h0520, 0);
        idle(2);
        `CHK(stb, 8'h80)
        host.pre();
        xs(0, 4'h2, 0, 16'h0000, 0);
        xs(0, 4'h5, 0, 16'h0000, 0);
        xs(0, 4'h6, 0, 16'h0000, 0);
        xs(1, 4'h7, 16'h001e, 0, 0);
        xs(1, 4'h7, 16'h001f, 0, 1);
        xs(1, 4'h7, 16'h0000, 0, 1);
        xs(0, 4'h7, 0, 16'h001e, 0);
        `CHK(addr, 5'h1e)
        xs(0, 4'h8, 0, 16'h0000, 1);
        ce = 1'b0;
        flt = 7'h02;
        idle(6);
        flt = 7'h00;
        ce = 1'b1;
        idle(6);
        xs(0, 4'h0, 0, 16'h0000, 0);
        arm = 1'b1;
        cont = 1'b0;
        idle(6);
        xs(0, 4'h4, 0, 16'h0020, 0);
        arm = 1'b0;
        idle(6);
        xs(0, 4'h4, 0, 16'h0000, 0);
        conclude();
    end
endmodule
